// *** common/power_seq_pkg.sv ***
// types shared by the power sequencer and its helpers
// assumes nothing beyond a SystemVerilog compiler
package power_seq_pkg;

    // ==========================================================
    // system states
    typedef enum logic [1:0] {
        sys_on,
        sys_light_sleep,
        sys_nv_sleep,
        sys_soft_off
    } sys_state_type;

    typedef enum logic [2:0] {
        seq_off,
        seq_supply,
        seq_good,
        seq_run,
        seq_down,
        seq_sleep
    } seq_type;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic ring_a;
        logic ring_b;
        logic pme_pci32;
        logic pme_pci_sec;
        logic pme_pci_pri;
        logic rtc_alarm;
        logic mouse;
        logic keyboard;
        logic usb;
    } wake_src_type;

    typedef struct packed {
        logic emergency_mgmt_port_n;
        logic id_button_n;
        logic nmi_button_n;
        logic reset_button_n;
        logic front_sleep_button_n;
        logic front_power_button_n;
    } buttons_type;

    typedef struct packed {
        logic mgmt_port;
        logic id;
        logic nmi;
        logic reset;
        logic sleep;
        logic power;
    } press_type;

    typedef struct packed {
        logic req;
        sys_state_type target;
    } sleep_cmd_type;

    typedef struct packed {
        logic shutdown;
        logic sleep;
        logic wake;
    } sci_type;

endpackage

// *** common/power_seq_regs.svh ***
// timing counts and reset values of the button and power sequencer
// assumes a 40 MHz core clock; included by bare name
`ifndef POWER_SEQ_REGS_SVH
`define POWER_SEQ_REGS_SVH

`define CORE_CLK_HZ 40000000
`define DEBOUNCE_MS 10
`define DEBOUNCE_CYC (`DEBOUNCE_MS * (`CORE_CLK_HZ / 1000))
`define DB_CNT_W 20
`define FORCE_OFF_MIN_S 4
`define FORCE_OFF_MAX_S 5
`define FORCE_OFF_CYC (`FORCE_OFF_MIN_S * `CORE_CLK_HZ)
`define CNT_W 28
`define PG_DELAY_CYC 28'h0000010
`define HUB_RST_CYC 28'h0000010
`define HARD_RST_CYC 8'h10
`define HARD_CNT_W 8
`define ACPI_RST 1'b0
`define LEGACY_WAKE_RST 9'h000

`endif

// *** logic/button_debounce.sv ***
// one active-low button: two-stage synchroniser, debounce, press pulse
// assumes an asynchronous pin and a single core clock
`include "power_seq_regs.svh"

module button_debounce #(
    parameter int unsigned DB_CYCLES = `DEBOUNCE_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_button_n,
    output logic o_press
);
    logic meta_q, sync_q, stable_q, stable_d, press_d;
    logic [`DB_CNT_W-1:0] cnt_q, cnt_d;

    // ==========================================================
    // debounce
    always_comb begin
        stable_d = stable_q;
        press_d = 1'b0;
        cnt_d = '0;
        if (sync_q != stable_q) begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == `DB_CNT_W'(DB_CYCLES - 1)) begin
                stable_d = sync_q;
                press_d = ~sync_q;
                cnt_d = '0;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            stable_q <= 1'b1;
            cnt_q <= '0;
            o_press <= 1'b0;
        end else if (i_ce) begin
            meta_q <= i_button_n;
            sync_q <= meta_q;
            stable_q <= stable_d;
            cnt_q <= cnt_d;
            o_press <= press_d;
        end
    end

    a_press_single: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (o_press && i_ce) |=> !o_press) else $error("press pulse longer than one cycle");

endmodule // button_debounce

// *** logic/button_wake_power_sequencer.sv ***
// front panel buttons, wake sources and power-state sequencing
// assumes button and wake pins are asynchronous, firmware commands and
// sleep requests come from logic on i_core_clk
`include "power_seq_regs.svh"

module button_wake_power_sequencer #(
    parameter int unsigned FORCE_OFF_CYCLES = `FORCE_OFF_CYC,
    parameter int unsigned DEBOUNCE_CYCLES = `DEBOUNCE_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire power_seq_pkg::buttons_type i_buttons,
    input wire power_seq_pkg::wake_src_type i_wake,
    input wire logic i_hub_wake,
    input wire logic i_acpi_enable_cmd,
    input wire power_seq_pkg::sleep_cmd_type i_sleep_cmd,
    input wire logic i_legacy_wake_load,
    input wire power_seq_pkg::wake_src_type i_legacy_wake_en,
    input wire logic i_front_id_led_en,
    output logic o_supply_power_request,
    output logic o_hub_power_good,
    output logic o_hub_reset_n,
    output logic o_system_reset_n,
    output logic o_cpu_nmi,
    output power_seq_pkg::sci_type o_sci,
    output logic o_hub_wake,
    output logic o_rear_id_led,
    output logic o_front_id_led,
    output logic o_acpi_mode,
    output power_seq_pkg::sys_state_type o_power_state
);
    // ==========================================================
    // declarations
    power_seq_pkg::press_type press;
    logic [5:0] btn_vec, press_vec;
    logic wake_hit;

    power_seq_pkg::seq_type seq_q, seq_d;
    logic [`CNT_W-1:0] cnt_q, cnt_d;
    logic supply_d, pg_d, hub_rst_n_d;
    power_seq_pkg::sys_state_type sys_d;

    logic acpi_d, sys_rst_n_d;
    logic [`HARD_CNT_W-1:0] rst_cnt_q, rst_cnt_d;
    power_seq_pkg::wake_src_type legacy_en_q, legacy_en_d;

    power_seq_pkg::sci_type sci_d;
    logic hub_wake_d, nmi_d, id_d, front_id_d;

    logic power_press, is_on, asleep, wake_any, hard_reset;

    // ==========================================================
    // button conditioning
    assign btn_vec = i_buttons;
    assign press = power_seq_pkg::press_type'(press_vec);

    for (genvar b = 0; b < 6; b++) begin : g_btn
        button_debounce #(
            .DB_CYCLES(DEBOUNCE_CYCLES)
        ) u_db (
            .i_core_clk(i_core_clk),
            .i_rst_b(i_rst_b),
            .i_ce(i_ce),
            .i_button_n(btn_vec[b]),
            .o_press(press_vec[b])
        );
    end

    wake_gate u_wake (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_wake(i_wake),
        .i_hub_wake(i_hub_wake),
        .i_acpi(o_acpi_mode),
        .i_state(o_power_state),
        .i_legacy_en(legacy_en_q),
        .o_wake(wake_hit)
    );

    // ==========================================================
    // shared conditions
    always_comb begin
        power_press = press.power | press.mgmt_port;
        is_on = (seq_q == power_seq_pkg::seq_run);
        asleep = (seq_q == power_seq_pkg::seq_off) || (seq_q == power_seq_pkg::seq_sleep);
        // sleep press wakes only under acpi
        wake_any = power_press | wake_hit | (o_acpi_mode & press.sleep);
        hard_reset = press.reset & is_on;
    end

    // ==========================================================
    // power sequencer
    always_comb begin
        seq_d = seq_q;
        cnt_d = cnt_q;
        supply_d = o_supply_power_request;
        pg_d = o_hub_power_good;
        hub_rst_n_d = o_hub_reset_n;
        sys_d = o_power_state;
        case (seq_q)
            power_seq_pkg::seq_off: begin
                supply_d = 1'b0;
                pg_d = 1'b0;
                hub_rst_n_d = 1'b0;
                if (wake_any) begin
                    seq_d = power_seq_pkg::seq_supply;
                    supply_d = 1'b1;
                    cnt_d = '0;
                end
            end
            power_seq_pkg::seq_supply: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == `PG_DELAY_CYC - 1'b1) begin
                    seq_d = power_seq_pkg::seq_good;
                    pg_d = 1'b1;
                    cnt_d = '0;
                end
            end
            power_seq_pkg::seq_good: begin
                cnt_d = cnt_q + 1'b1;
                if (cnt_q == `HUB_RST_CYC - 1'b1) begin
                    seq_d = power_seq_pkg::seq_run;
                    hub_rst_n_d = 1'b1;
                    sys_d = power_seq_pkg::sys_on;
                end
            end
            power_seq_pkg::seq_run: begin
                if (i_sleep_cmd.req && i_sleep_cmd.target == power_seq_pkg::sys_light_sleep) begin
                    // light sleep keeps supply and context
                    seq_d = power_seq_pkg::seq_sleep;
                    sys_d = power_seq_pkg::sys_light_sleep;
                end else if (i_sleep_cmd.req && i_sleep_cmd.target != power_seq_pkg::sys_on) begin
                    seq_d = power_seq_pkg::seq_off;
                    supply_d = 1'b0;
                    pg_d = 1'b0;
                    hub_rst_n_d = 1'b0;
                    sys_d = i_sleep_cmd.target;
                end else if (power_press && !o_acpi_mode) begin
                    seq_d = power_seq_pkg::seq_down;
                    cnt_d = '0;
                end
            end
            power_seq_pkg::seq_down: begin
                cnt_d = cnt_q + 1'b1;
                if ((i_sleep_cmd.req && i_sleep_cmd.target != power_seq_pkg::sys_on &&
                     i_sleep_cmd.target != power_seq_pkg::sys_light_sleep) ||
                    cnt_q == `CNT_W'(FORCE_OFF_CYCLES - 1)) begin
                    seq_d = power_seq_pkg::seq_off;
                    supply_d = 1'b0;
                    pg_d = 1'b0;
                    hub_rst_n_d = 1'b0;
                    sys_d = power_seq_pkg::sys_soft_off;
                end
            end
            power_seq_pkg::seq_sleep: begin
                if (wake_any) begin
                    seq_d = power_seq_pkg::seq_run;
                    sys_d = power_seq_pkg::sys_on;
                end
            end
            default: begin
                seq_d = power_seq_pkg::seq_off;
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            seq_q <= power_seq_pkg::seq_off;
            cnt_q <= '0;
            o_supply_power_request <= 1'b0;
            o_hub_power_good <= 1'b0;
            o_hub_reset_n <= 1'b0;
            o_power_state <= power_seq_pkg::sys_soft_off;
        end else if (i_ce) begin
            seq_q <= seq_d;
            cnt_q <= cnt_d;
            o_supply_power_request <= supply_d;
            o_hub_power_good <= pg_d;
            o_hub_reset_n <= hub_rst_n_d;
            o_power_state <= sys_d;
        end
    end

    // ==========================================================
    // mode, configuration and hard reset
    always_comb begin
        acpi_d = o_acpi_mode;
        sys_rst_n_d = o_system_reset_n;
        rst_cnt_d = rst_cnt_q;
        legacy_en_d = legacy_en_q;
        if (hard_reset) begin
            acpi_d = 1'b0;
            sys_rst_n_d = 1'b0;
            rst_cnt_d = '0;
        end else if (i_acpi_enable_cmd) begin
            acpi_d = 1'b1;
        end
        if (!o_system_reset_n && !hard_reset) begin
            rst_cnt_d = rst_cnt_q + 1'b1;
            if (rst_cnt_q == `HARD_RST_CYC - 1'b1) begin
                sys_rst_n_d = 1'b1;
            end
        end
        if (i_legacy_wake_load) begin
            legacy_en_d = i_legacy_wake_en;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_acpi_mode <= `ACPI_RST;
            o_system_reset_n <= 1'b1;
            rst_cnt_q <= '0;
            legacy_en_q <= `LEGACY_WAKE_RST;
        end else if (i_ce) begin
            o_acpi_mode <= acpi_d;
            o_system_reset_n <= sys_rst_n_d;
            rst_cnt_q <= rst_cnt_d;
            legacy_en_q <= legacy_en_d;
        end
    end

    // ==========================================================
    // events to software, processor and LEDs
    always_comb begin
        sci_d = '0;
        hub_wake_d = 1'b0;
        nmi_d = press.nmi;
        id_d = o_rear_id_led;
        if (is_on && o_acpi_mode && power_press) begin
            sci_d.shutdown = 1'b1;
        end
        if (o_acpi_mode && press.sleep) begin
            if (is_on) begin
                sci_d.sleep = 1'b1;
            end
            if (asleep) begin
                hub_wake_d = 1'b1;
                sci_d.wake = 1'b1;
            end
        end
        if (press.id) begin
            id_d = ~o_rear_id_led;
        end
        front_id_d = id_d & i_front_id_led_en;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            o_sci <= '0;
            o_hub_wake <= 1'b0;
            o_cpu_nmi <= 1'b0;
            o_rear_id_led <= 1'b0;
            o_front_id_led <= 1'b0;
        end else if (i_ce) begin
            o_sci <= sci_d;
            o_hub_wake <= hub_wake_d;
            o_cpu_nmi <= nmi_d;
            o_rear_id_led <= id_d;
            o_front_id_led <= front_id_d;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    a_enable_acpi: assert property ((i_ce && i_acpi_enable_cmd && !hard_reset) |=> o_acpi_mode)
        else $error("enable command did not enter acpi mode");
    a_reset_legacy: assert property ($rose(i_rst_b) |-> !o_acpi_mode && legacy_en_q == 9'h000)
        else $error("reset left acpi or legacy wake enabled");
    a_press_keeps_on: assert property ((i_ce && is_on && o_acpi_mode && power_press &&
        !i_sleep_cmd.req) |=> o_supply_power_request && is_on && o_sci.shutdown)
        else $error("acpi power press changed power state");
    a_sleep_ignored: assert property ((i_ce && !o_acpi_mode && press.sleep) |=> !o_sci.sleep && !o_hub_wake)
        else $error("sleep press acted in legacy mode");
    a_off_wakes: assert property ((i_ce && seq_q == power_seq_pkg::seq_off && press.mgmt_port)
        |=> o_supply_power_request)
        else $error("management port did not start power-up");
    a_good_then_reset: assert property ($rose(o_hub_reset_n) |-> o_hub_power_good && $past(o_hub_power_good))
        else $error("hub reset released before power good");
    a_force_bound: assert property ((seq_q == power_seq_pkg::seq_down) |-> cnt_q < `CNT_W'(FORCE_OFF_CYCLES))
        else $error("forced power-off overran");
    a_sleep_on_req: assert property ((i_ce && is_on && o_acpi_mode && press.sleep) |=> o_sci.sleep && !o_hub_wake)
        else $error("sleep request missing");
    a_sleep_wakes: assert property ((i_ce && asleep && o_acpi_mode && press.sleep) |=> o_hub_wake && o_sci.wake)
        else $error("sleep press while asleep gave no wake");
    a_hard_reset: assert property ((i_ce && hard_reset) |=> !o_system_reset_n && !o_acpi_mode)
        else $error("reset button had no effect");
    a_nmi_pass: assert property ((i_ce && press.nmi) |=> o_cpu_nmi)
        else $error("nmi not forwarded");
    a_id_toggle: assert property ((i_ce && press.id) |=> o_rear_id_led != $past(o_rear_id_led))
        else $error("id lamp did not toggle");

endmodule // button_wake_power_sequencer

// *** logic/wake_gate.sv ***
// wake-source qualification by mode and sleep state
// assumes wake pins are asynchronous active-high levels
`include "power_seq_regs.svh"

module wake_gate (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire power_seq_pkg::wake_src_type i_wake,
    input wire logic i_hub_wake,
    input wire logic i_acpi,
    input wire power_seq_pkg::sys_state_type i_state,
    input wire power_seq_pkg::wake_src_type i_legacy_en,
    output logic o_wake
);
    power_seq_pkg::wake_src_type meta_q, sync_q, prev_q, rise;
    logic hub_meta_q, hub_sync_q, hub_prev_q, wake_d;

    function automatic logic wake_ok(power_seq_pkg::wake_src_type ev, logic acpi,
                                     power_seq_pkg::sys_state_type st,
                                     power_seq_pkg::wake_src_type en);
        logic broad;
        broad = ev.ring_a | ev.ring_b | ev.pme_pci32 | ev.pme_pci_pri | ev.rtc_alarm;
        if (acpi) begin
            wake_ok = broad | ev.pme_pci_sec
                    // input devices only from light sleep
                    | ((st == power_seq_pkg::sys_light_sleep) & (ev.mouse | ev.keyboard));
        end else begin
            wake_ok = |{ev.ring_a & en.ring_a, ev.ring_b & en.ring_b, ev.pme_pci32 & en.pme_pci32,
                        ev.pme_pci_pri & en.pme_pci_pri, ev.rtc_alarm & en.rtc_alarm};
        end
    endfunction

    always_comb begin
        rise = sync_q & ~prev_q;
        wake_d = wake_ok(rise, i_acpi, i_state, i_legacy_en) | (hub_sync_q & ~hub_prev_q);
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
            hub_meta_q <= 1'b0;
            hub_sync_q <= 1'b0;
            hub_prev_q <= 1'b0;
            o_wake <= 1'b0;
        end else if (i_ce) begin
            meta_q <= i_wake;
            sync_q <= meta_q;
            prev_q <= sync_q;
            hub_meta_q <= i_hub_wake;
            hub_sync_q <= hub_meta_q;
            hub_prev_q <= hub_sync_q;
            o_wake <= wake_d;
        end
    end

    a_usb_no_wake: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
        (i_ce && rise == 9'h001 && !(hub_sync_q && !hub_prev_q)) |=> !o_wake)
        else $error("usb edge produced a wake");

endmodule // wake_gate

// *** tb/button_wake_power_sequencer_tb.sv ***
// self-checking bench for the button and power sequencer
// assumes short debounce and force-off counts set at the instance
module button_wake_power_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DB = 4;
    localparam power_seq_pkg::sys_state_type ON = power_seq_pkg::sys_on;
    localparam power_seq_pkg::sys_state_type OFF = power_seq_pkg::sys_soft_off;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic [5:0] btn = 6'h3f;
    logic acmd = 1'h0;
    logic hwk = 1'h0;
    logic load = 1'h0;
    logic fen = 1'h1;
    power_seq_pkg::wake_src_type wk = '0;
    power_seq_pkg::wake_src_type wen = '0;
    power_seq_pkg::sleep_cmd_type scmd = '0;
    power_seq_pkg::sci_type sci;
    power_seq_pkg::sys_state_type st;
    logic sup, pg, hrst_n, srst_n, nmi, hwake, rled, fled, acpi, hub_on, ord_err;
    int fails = 0;
    int tests_run = 0;
    int cyc = 0;
    int rlow = 0;
    int pc[5] = '{default: 0};
    always #12.5 clk = ~clk;
    button_wake_power_sequencer #(.FORCE_OFF_CYCLES(200), .DEBOUNCE_CYCLES(DB)) u_dut (
        .i_core_clk(clk), .i_rst_b(rst_b), .i_ce(1'h1), .i_buttons(btn), .i_wake(wk),
        .i_hub_wake(hwk), .i_acpi_enable_cmd(acmd), .i_sleep_cmd(scmd),
        .i_legacy_wake_load(load), .i_legacy_wake_en(wen), .i_front_id_led_en(fen),
        .o_supply_power_request(sup), .o_hub_power_good(pg), .o_hub_reset_n(hrst_n),
        .o_system_reset_n(srst_n), .o_cpu_nmi(nmi), .o_sci(sci), .o_hub_wake(hwake),
        .o_rear_id_led(rled), .o_front_id_led(fled), .o_acpi_mode(acpi), .o_power_state(st));
    hub_model u_hub (.i_core_clk(clk), .i_pg(pg), .i_rst_n(hrst_n), .o_on(hub_on), .o_order_err(ord_err));
    // ========
    // pulse counters and hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (srst_n === 1'h0) rlow <= rlow + 1;
        if (sci.wake === 1'h1) pc[0] <= pc[0] + 1;
        if (sci.sleep === 1'h1) pc[1] <= pc[1] + 1;
        if (sci.shutdown === 1'h1) pc[2] <= pc[2] + 1;
        if (nmi === 1'h1) pc[3] <= pc[3] + 1;
        if (hwake === 1'h1) pc[4] <= pc[4] + 1;
        if (cyc == 6000) begin
            fails++;
            summarize();
        end
    end
    // ========
    // helpers
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic press(input int b);
        @(posedge clk) btn[b] <= 1'h0;
        repeat (DB + 8) @(posedge clk);
        btn[b] <= 1'h1;
        repeat (DB + 8) @(posedge clk);
        #1;
    endtask
    task automatic wait_state(input power_seq_pkg::sys_state_type s);
        for (int i = 0; i < 400 && st !== s; i++) @(posedge clk) #1;
        @(posedge clk) #1;
    endtask
    task automatic hard_reset();
        @(posedge clk) rst_b <= 1'h0;
        repeat (2) @(posedge clk);
        rst_b <= 1'h1;
        @(posedge clk) #1;
    endtask
    task automatic pulse_wake(input power_seq_pkg::wake_src_type v);
        @(posedge clk) wk <= v;
        repeat (40) @(posedge clk);
        wk <= '0;
        @(posedge clk) #1;
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ========
    // scenarios
    task automatic t_power_up();
        press(0);
        wait_state(ON);
        chk("state", ON, st);
        chk("supply", 1'h1, sup);
        chk("hub_on", 1'h1, hub_on);
        chk("order", 1'h0, ord_err);
        $display("test power_up done");
    endtask
    task automatic t_buttons();
        int b[5];
        int r;
        b = pc;
        press(1);
        chk("legacy_sleep", 8'h00, pc[1] - b[1] + pc[4] - b[4]);
        press(3);
        chk("nmi", 8'h01, pc[3] - b[3]);
        press(4);
        chk("rear_led", 1'h1, rled);
        chk("front_led", 1'h1, fled);
        @(posedge clk) fen <= 1'h0;
        repeat (2) @(posedge clk) #1;
        chk("front_off", 1'h0, fled);
        r = rlow;
        press(2);
        chk("reset_len", 8'h10, rlow - r);
        $display("test buttons done");
    endtask
    task automatic t_acpi();
        int b[5];
        b = pc;
        @(posedge clk) acmd <= 1'h1;
        @(posedge clk) acmd <= 1'h0;
        @(posedge clk) #1;
        chk("acpi", 1'h1, acpi);
        press(0);
        chk("shutdown", 8'h01, pc[2] - b[2]);
        chk("stay_on", ON, st);
        press(1);
        chk("sleep_req", 8'h01, pc[1] - b[1]);
        @(posedge clk) scmd <= '{1'h1, power_seq_pkg::sys_light_sleep};
        @(posedge clk) scmd <= '0;
        wait_state(power_seq_pkg::sys_light_sleep);
        chk("light", power_seq_pkg::sys_light_sleep, st);
        press(1);
        chk("hub_wake", 8'h01, pc[4] - b[4]);
        chk("wake_req", 8'h01, pc[0] - b[0]);
        wait_state(ON);
        chk("resumed", ON, st);
        @(posedge clk) scmd <= '{1'h1, power_seq_pkg::sys_light_sleep};
        @(posedge clk) scmd <= '0;
        wait_state(power_seq_pkg::sys_light_sleep);
        pulse_wake(9'h004);
        wait_state(ON);
        chk("mouse_wake", ON, st);
        hard_reset();
        chk("acpi_rst", 1'h0, acpi);
        chk("off_rst", OFF, st);
        @(posedge clk) hwk <= 1'h1;
        repeat (4) @(posedge clk);
        hwk <= 1'h0;
        wait_state(ON);
        chk("hub_wake_up", ON, st);
        @(posedge clk) scmd <= '{1'h1, power_seq_pkg::sys_nv_sleep};
        @(posedge clk) scmd <= '0;
        wait_state(power_seq_pkg::sys_nv_sleep);
        chk("nv_sleep", power_seq_pkg::sys_nv_sleep, st);
        chk("nv_supply", 1'h0, sup);
        $display("test acpi done");
    endtask
    task automatic t_legacy();
        press(5);
        wait_state(ON);
        chk("emp_up", ON, st);
        press(0);
        chk("press_no_cut", 1'h1, sup);
        wait_state(OFF);
        chk("forced_off", 1'h0, sup);
        pulse_wake(9'h008);
        chk("wake_disabled", OFF, st);
        @(posedge clk) begin
            wen <= 9'h1ff;
            load <= 1'h1;
        end
        @(posedge clk) load <= 1'h0;
        pulse_wake(9'h001);
        chk("usb_never", OFF, st);
        pulse_wake(9'h027);
        chk("never_wake", OFF, st);
        pulse_wake(9'h008);
        wait_state(ON);
        chk("rtc_wake", ON, st);
        $display("test legacy done");
    endtask
    initial begin
        hard_reset();
        chk("reset_supply", 1'h0, sup);
        chk("reset_state", OFF, st);
        t_power_up();
        t_buttons();
        t_acpi();
        t_legacy();
        summarize();
    end
endmodule // button_wake_power_sequencer_tb

// *** tb/hub_model.sv ***
// hub stand-in: watches power good and hub reset from the sequencer
// assumes both come from flops on i_core_clk
module hub_model (
    input wire logic i_core_clk,
    input wire logic i_pg,
    input wire logic i_rst_n,
    output logic o_on,
    output logic o_order_err
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========
    // hub state
    // on only with both
    always @(posedge i_core_clk) begin
        o_on <= i_pg && i_rst_n;
        if (i_rst_n === 1'h1 && i_pg !== 1'h1) begin
            o_order_err <= 1'h1;
        end else if (o_order_err !== 1'h1) begin
            o_order_err <= 1'h0;
        end
    end
endmodule // hub_model
